// ==== logic/dsdt_pkg.sv ====
// Purpose: constants for the demodulator sigma-delta test output block
// Assumes: 200 MHz aclk, AXI4-Lite register access, 16-bit demod samples
// Notes:   register offsets and field positions live here only
//
// Function
// [RULE_01] the modulator steps once per recovery clock tick, one bit each.
// [RULE_02] at the normal 32x data rate tick the modulator still works.
// [RULE_03] raising the tick to the demodulator clock stops clock recovery.
// [RULE_04] a test register bit picks correlator or linear demod as input.
// [RULE_05] on the linear path a programmed dc offset is subtracted first.
// [RULE_06] the linear value follows frequency, so it carries an if offset.
// [RULE_07] software writes half the measured if into the offset field.
// [RULE_08] the corrected linear value is multiplied by a programmed gain.
// [RULE_09] software enables the test output by selecting test mode 7.
// [RULE_10] for the linear path software also selects test mode 10.
// [RULE_11] software writes the offset word into register 13.
// [RULE_12] the result leaves as a 1-bit oversampled stream on a pin.
// [RULE_13] the recovery clock is driven on the multiplexed output pin.
// [RULE_14] software first enables the pll test modes in register 0.
// [RULE_15] the modulator is a first-order loop emitting the sign bit.
// [RULE_16] the normal demodulator datapath is never altered by the test.
package dsdt_pkg;
    // ****************************************************************
    // register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] ADDR_PLL_CTRL  = 8'h00; // register 0
    localparam logic [7:0] ADDR_TEST      = 8'h30; // register 12
    localparam logic [7:0] ADDR_OFFSET    = 8'h34; // register 13
    localparam logic [7:0] ADDR_STATUS    = 8'h40;
    // ****************************************************************
    // fields
    // ****************************************************************
    localparam int PLL_TM_HI  = 31;             // pll test enable nibble
    localparam int PLL_TM_LO  = 28;
    localparam logic [3:0] PLL_TM_KEY = 4'hd;
    localparam int TM_HI      = 17;             // digital test mode field
    localparam int TM_LO      = 13;
    localparam logic [4:0] TM_DAC     = 5'h0e;  // test mode 7 encoding
    localparam logic [4:0] TM_OFS     = 5'h14;  // test mode 10 encoding
    localparam int TM_SRC_BIT = 4;              // 1 = linear demod source
    localparam int TM_FAST_BIT = 5;             // tick at demod clock rate
    localparam int TM_CLKOUT_BIT = 8;           // clock on mux pin
    localparam int OFS_HI     = 27;             // offset removal field
    localparam int OFS_LO     = 16;
    localparam int GAIN_HI    = 31;             // signal gain field
    localparam int GAIN_LO    = 28;
    localparam logic [31:0] TEST_RST   = 32'h0000_0000;
    localparam logic [31:0] OFFSET_RST = 32'h0000_0000;
    // ****************************************************************
    // datapath
    // ****************************************************************
    localparam int SMP_W = 16;
    localparam int ACC_W = 20;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ==== logic/dsdt_input_path.sv ====
// Purpose: source select, offset removal and gain for the modulator
// Assumes: samples are signed and arrive on aclk
// Notes:   purely combinational path feeding the loop register
`timescale 1ns/10ps
`default_nettype none
module dsdt_input_path (
    input  wire logic                           sel_linear,
    input  wire logic                           ofs_en,
    input  wire logic signed [dsdt_pkg::SMP_W-1:0] corr_sample,
    input  wire logic signed [dsdt_pkg::SMP_W-1:0] lin_sample,
    input  wire logic [11:0]                    ofs_half,
    input  wire logic [3:0]                     gain,
    output logic signed [dsdt_pkg::SMP_W-1:0]   mod_in
);
    logic signed [dsdt_pkg::SMP_W+1:0] diff;
    logic signed [dsdt_pkg::SMP_W+5:0] scaled;
    // half the if is stored, so twice it is removed; gain is 1..16
    always_comb begin
        diff   = 18'(lin_sample)                            // RULE_06
               - (ofs_en ? 18'(signed'({1'b0, ofs_half, 1'b0})) : 18'sd0); // RULE_05
        scaled = 22'(diff) * 22'(signed'({1'b0, gain})) + 22'(diff); // RULE_08
        if (!sel_linear) begin
            mod_in = corr_sample;                           // RULE_04
        end else if (scaled > 22'sd32767) begin
            mod_in = 16'sh7fff;                             // saturate high
        end else if (scaled < -22'sd32768) begin
            mod_in = -16'sh8000;
        end else begin
            mod_in = scaled[dsdt_pkg::SMP_W-1:0];
        end
    end
endmodule
`default_nettype wire

// ==== logic/dsdt_modulator.sv ====
// Purpose: first-order sigma-delta loop, one bit per tick
// Assumes: tick is a one-cycle pulse on aclk
// Notes:   state held in one packed struct
`timescale 1ns/10ps
`default_nettype none
module dsdt_modulator (
    input  wire logic                              aclk,
    input  wire logic                              aresetn,
    input  wire logic                              enable,
    input  wire logic                              tick,
    input  wire logic signed [dsdt_pkg::SMP_W-1:0] mod_in,
    output logic                                   bit_out
);
    typedef struct packed {
        logic signed [dsdt_pkg::ACC_W-1:0] acc;
        logic                              bit_q;
    } dsdt_mod_t;
    dsdt_mod_t st, next_st;
    logic signed [dsdt_pkg::ACC_W-1:0] fb;
    // feedback of full scale keeps ones density equal to input level
    always_comb begin
        next_st = st;
        fb = st.bit_q ? 20'sd32768 : -20'sd32768;
        if (!enable) begin
            next_st = '0;
        end else if (tick) begin                            // RULE_01
            next_st.acc   = st.acc + 20'(mod_in) - fb;      // RULE_15
            next_st.bit_q = ~next_st.acc[dsdt_pkg::ACC_W-1]; // RULE_15
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) st <= '0;
        else st <= next_st;
    end
    assign bit_out = st.bit_q;
endmodule
`default_nettype wire

// ==== logic/dsdt_top.sv ====
// Purpose: demodulator sigma-delta test output with axi4-lite registers
// Assumes: ticks from the recovery clock generator arrive on aclk
// Notes:   the normal demod outputs pass through untouched
`timescale 1ns/10ps
`default_nettype none
module dsdt_top (
    input  wire logic                              aclk,
    input  wire logic                              aresetn,
    // ********************* axi4-lite slave *********************
    input  wire logic [7:0]                        s_axi_awaddr,
    input  wire logic                              s_axi_awvalid,
    output logic                                   s_axi_awready,
    input  wire logic [31:0]                       s_axi_wdata,
    input  wire logic [3:0]                        s_axi_wstrb,
    input  wire logic                              s_axi_wvalid,
    output logic                                   s_axi_wready,
    output logic [1:0]                             s_axi_bresp,
    output logic                                   s_axi_bvalid,
    input  wire logic                              s_axi_bready,
    input  wire logic [7:0]                        s_axi_araddr,
    input  wire logic                              s_axi_arvalid,
    output logic                                   s_axi_arready,
    output logic [31:0]                            s_axi_rdata,
    output logic [1:0]                             s_axi_rresp,
    output logic                                   s_axi_rvalid,
    input  wire logic                              s_axi_rready,
    // ********************* demodulator side ********************
    input  wire logic                              recovery_tick,
    input  wire logic                              demodulator_tick,
    input  wire logic signed [dsdt_pkg::SMP_W-1:0] corr_sample,
    input  wire logic signed [dsdt_pkg::SMP_W-1:0] lin_sample,
    input  wire logic                              demod_data_in,
    output logic                                   demod_data_out,
    output logic                                   recovery_enable,
    // ************************** pins ***************************
    output logic                                   test_bit_pin,
    output logic                                   multiplexed_output_pin
);
    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [31:0] pll_ctrl;
        logic [31:0] test;
        logic [31:0] offset;
        logic        aw_got;
        logic [7:0]  aw_addr;
        logic        w_got;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        clk_q;
        logic        data_q;
    } dsdt_state_t;
    dsdt_state_t st, next_st;

    logic        pll_tm;
    logic        dac_on;
    logic        ofs_on;
    logic        fast;
    logic        tick;
    logic        mod_bit;
    logic [4:0]  tm;
    logic signed [dsdt_pkg::SMP_W-1:0] mod_in;
    logic [31:0] merged;
    logic [31:0] status;

    // ****************************************************************
    // decode of test settings
    // ****************************************************************
    // test modes only count once the pll test key is in register 0
    assign pll_tm = st.pll_ctrl[dsdt_pkg::PLL_TM_HI:dsdt_pkg::PLL_TM_LO]
                    == dsdt_pkg::PLL_TM_KEY;                       // RULE_14
    assign tm     = st.test[dsdt_pkg::TM_HI:dsdt_pkg::TM_LO];
    assign dac_on = pll_tm && (tm == dsdt_pkg::TM_DAC
                               || tm == dsdt_pkg::TM_OFS);         // RULE_09
    assign ofs_on = tm == dsdt_pkg::TM_OFS;                        // RULE_10
    assign fast   = dac_on && st.test[dsdt_pkg::TM_FAST_BIT];
    // fast tick trades clock recovery for oversampling quality
    assign tick   = fast ? demodulator_tick : recovery_tick;      // RULE_02
    assign recovery_enable = !fast;                                // RULE_03
    assign status = {29'h0, fast, st.data_q, dac_on};

    // ****************************************************************
    // datapath
    // ****************************************************************
    dsdt_input_path u_path (
        .sel_linear (st.test[dsdt_pkg::TM_SRC_BIT]),
        .ofs_en     (ofs_on),
        .corr_sample(corr_sample),
        .lin_sample (lin_sample),
        .ofs_half   (st.offset[dsdt_pkg::OFS_HI:dsdt_pkg::OFS_LO]), // RULE_07
        .gain       (st.offset[dsdt_pkg::GAIN_HI:dsdt_pkg::GAIN_LO]),
        .mod_in     (mod_in)
    );

    dsdt_modulator u_mod (
        .aclk   (aclk),
        .aresetn(aresetn),
        .enable (dac_on),
        .tick   (tick),
        .mod_in (mod_in),
        .bit_out(mod_bit)
    );

    // ****************************************************************
    // next state: bus slave and pin registers
    // ****************************************************************
    always_comb begin
        next_st = st;
        for (int i = 0; i < 32; i++) begin
            merged[i] = st.w_strb[i/8];                 // byte-lane mask
        end
        // write address and data may arrive in either order
        if (s_axi_awvalid && !st.aw_got) begin
            next_st.aw_got  = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st.w_got) begin
            next_st.w_got  = 1'b1;
            next_st.w_data = s_axi_wdata;
            next_st.w_strb = s_axi_wstrb;
        end
        if (st.aw_got && st.w_got && !st.bvalid) begin
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = dsdt_pkg::RESP_OKAY;
            unique case (st.aw_addr)
                dsdt_pkg::ADDR_PLL_CTRL: next_st.pll_ctrl =
                    (st.pll_ctrl & ~merged) | (st.w_data & merged);
                dsdt_pkg::ADDR_TEST: next_st.test =
                    (st.test & ~merged) | (st.w_data & merged);    // RULE_04
                dsdt_pkg::ADDR_OFFSET: next_st.offset =
                    (st.offset & ~merged) | (st.w_data & merged);  // RULE_11
                default: next_st.bresp = dsdt_pkg::RESP_SLVERR;
            endcase
        end
        if (st.bvalid && s_axi_bready) next_st.bvalid = 1'b0;
        // one read at a time; answer one cycle after address taken
        if (s_axi_arvalid && !st.rvalid) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = dsdt_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                dsdt_pkg::ADDR_PLL_CTRL: next_st.rdata = st.pll_ctrl;
                dsdt_pkg::ADDR_TEST:     next_st.rdata = st.test;
                dsdt_pkg::ADDR_OFFSET:   next_st.rdata = st.offset;
                dsdt_pkg::ADDR_STATUS:   next_st.rdata = status;
                default: begin
                    next_st.rdata = 32'h0000_0000;
                    next_st.rresp = dsdt_pkg::RESP_SLVERR;
                end
            endcase
        end else if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        // pins: level of tick stream on mux pin, bit stream beside it
        next_st.clk_q  = dac_on && st.test[dsdt_pkg::TM_CLKOUT_BIT]
                         && tick;                                  // RULE_13
        next_st.data_q = dac_on && mod_bit;                        // RULE_12
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st        <= '0;
            st.test   <= dsdt_pkg::TEST_RST;
            st.offset <= dsdt_pkg::OFFSET_RST;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign s_axi_awready = !st.aw_got;
    assign s_axi_wready  = !st.w_got;
    assign s_axi_bvalid  = st.bvalid;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_arready = !st.rvalid;
    assign s_axi_rvalid  = st.rvalid;
    assign s_axi_rdata   = st.rdata;
    assign s_axi_rresp   = st.rresp;
    assign demod_data_out = demod_data_in;                         // RULE_16
    assign test_bit_pin   = st.data_q;
    assign multiplexed_output_pin = st.clk_q;
endmodule
`default_nettype wire

// ==== dv/dsdt_bit_sink.sv ====
// Purpose: far-side model, a processor input port taking the test stream
// Assumes: bit is sampled in every aclk cycle where the stream clock is high
// Notes:   counts ones and bits; clr restarts a measurement window
`timescale 1ns/10ps
`default_nettype none
module dsdt_bit_sink (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clr,
    input  wire logic        sd_bit,
    input  wire logic        sd_clk,
    output logic [15:0]      ones,
    output logic [15:0]      total
);
    // ****************************************
    // capture on the stream clock
    // ****************************************
    // a port only sees bits framed by the clock; stray bits are ignored
    always_ff @(posedge aclk) begin
        if (!aresetn || clr) begin
            ones  <= 16'h0000;
            total <= 16'h0000;
        end else if (sd_clk) begin
            total <= total + 16'h0001;
            ones  <= ones + {15'h0000, sd_bit};
        end
    end
endmodule
`default_nettype wire

// ==== dv/dsdt_top_asserts.sv ====
// Purpose: port-level checks of the sigma-delta test output block
// Assumes: ticks are one-cycle pulses on aclk
// Notes:   bound into dsdt_top, watches its ports only
`timescale 1ns/10ps
`default_nettype none
module dsdt_top_asserts (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        recovery_tick,
    input  wire logic        demodulator_tick,
    input  wire logic        demod_data_in,
    input  wire logic        demod_data_out,
    input  wire logic        recovery_enable,
    input  wire logic        test_bit_pin,
    input  wire logic        multiplexed_output_pin
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ****************************************
    // assertions
    // ****************************************
    demod_thru_a: assert property (
        demod_data_out == demod_data_in) else $error("demod path altered");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
    r_answer_a: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read not answered");
    err_data_zero_a: assert property (
        s_axi_rvalid && s_axi_rresp == dsdt_pkg::RESP_SLVERR
        |-> s_axi_rdata == 32'h0000_0000) else $error("error read data");
    mux_slow_a: assert property (
        multiplexed_output_pin && recovery_enable && $stable(recovery_enable)
        |-> $past(recovery_tick)) else $error("mux pin not recovery tick");
    mux_fast_a: assert property (
        multiplexed_output_pin && !recovery_enable && $stable(recovery_enable)
        |-> $past(demodulator_tick)) else $error("mux pin not demod tick");
    // loop bit lands one edge after the tick, the pin one edge later,
    // and only the tick of the mode then in force may raise it
    bit_on_tick_a: assert property ($rose(test_bit_pin)
        |-> ($past(recovery_enable, 2) ? $past(recovery_tick, 2)
             : $past(demodulator_tick, 2)))
        else $error("test bit moved without a tick");
    // main scenarios reached
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rresp == dsdt_pkg::RESP_SLVERR);
    cover property ($rose(test_bit_pin) && !recovery_enable);
endmodule
bind dsdt_top dsdt_top_asserts u_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .recovery_tick(recovery_tick),
    .demodulator_tick(demodulator_tick), .demod_data_in(demod_data_in),
    .demod_data_out(demod_data_out), .recovery_enable(recovery_enable),
    .test_bit_pin(test_bit_pin),
    .multiplexed_output_pin(multiplexed_output_pin));
`default_nettype wire

// ==== dv/tb_demod_sigma_delta_test_output.sv ====
// Purpose: self-checking bench driving registers and samples
// Assumes: ticks every 4 cycles (recovery) and every 2 cycles (demod)
// Notes:   density windows are 400 cycles, loose bounds allow warm-up
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
    $display("FAIL t=%0t got %h exp %h", $time, a, b); end end
module tb_demod_sigma_delta_test_output;
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic [7:0] awa = 0, ara = 0, dv_cnt = 0;
    logic [31:0] wd = 0, rdat;
    logic [1:0] resp;
    logic [3:0] ws = 4'hf;
    logic rtk = 0, dtk = 0, ddi = 0, clr = 0;
    logic signed [15:0] corr = 0, lin = 0;
    wire logic awr, wr_rdy, bv, arr, rv, ddo, ren, tbit, mux;
    wire logic [1:0] brs, rrs;
    wire logic [31:0] rd;
    wire logic [15:0] ones, tot;
    int miscompares = 0, n_tests = 0, cyc = 0;
    dsdt_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
        .s_axi_bresp(brs), .s_axi_bvalid(bv), .s_axi_bready(bry),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rrs), .s_axi_rvalid(rv),
        .s_axi_rready(rry), .recovery_tick(rtk), .demodulator_tick(dtk),
        .corr_sample(corr), .lin_sample(lin), .demod_data_in(ddi),
        .demod_data_out(ddo), .recovery_enable(ren), .test_bit_pin(tbit),
        .multiplexed_output_pin(mux));
    dsdt_bit_sink u_sink (.aclk(aclk), .aresetn(aresetn), .clr(clr),
        .sd_bit(tbit), .sd_clk(mux), .ones(ones), .total(tot));
    // ****************************************
    // clock, ticks, watchdog
    // ****************************************
    initial forever #2.5 aclk = ~aclk;
    always @(posedge aclk) begin
        dv_cnt <= dv_cnt + 8'h01;
        rtk <= (dv_cnt[1:0] == 2'b00);
        dtk <= dv_cnt[0];
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    // ****************************************
    // axi4-lite master tasks
    // ****************************************
    // changes follow a rising edge; readies and answers are taken at
    // the edge where they are sampled high; only the watchdog ends a wait
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        logic ad, dd;
        ad = 0;
        dd = 0;
        @(posedge aclk);
        awa <= a; wd <= d; ws <= s; awv <= 1; wv <= 1; bry <= 1;
        while (!(ad && dd)) begin
            @(posedge aclk);
            if (!ad && awr) begin
                ad = 1;
                awv <= 0;
            end
            if (!dd && wr_rdy) begin
                dd = 1;
                wv <= 0;
            end
        end
        do @(posedge aclk); while (!bv);
        resp = brs;
    endtask
    // rready stays high between reads, so no second drive in one step
    task automatic rdx(input logic [7:0] a);
        @(posedge aclk);
        ara <= a; arv <= 1; rry <= 1;
        do @(posedge aclk); while (!arr);
        arv <= 0;
        do @(posedge aclk); while (!rv);
        rdat = rd;
        resp = rrs;
    endtask
    // restart the sink, then let 400 cycles of stream pass
    task automatic meas();
        @(posedge aclk);
        clr <= 1;
        @(posedge aclk);
        clr <= 0;
        repeat (400) @(posedge aclk);
        @(negedge aclk);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        @(negedge aclk);
        `CHK(tbit, 1'b0)
        `CHK(ren, 1'b1)
        rdx(8'h30); `CHK(rdat, 32'h0000_0000)
        rdx(8'h34); `CHK(rdat, 32'h0000_0000)
        rdx(8'h44); `CHK(resp, dsdt_pkg::RESP_SLVERR)
        `CHK(rdat, 32'h0000_0000)
        wr(8'h44, 32'h0000_0001, 4'hf); `CHK(resp, dsdt_pkg::RESP_SLVERR)
        // one byte lane only: the other lanes keep their reset value
        wr(8'h34, 32'hffff_ffff, 4'h4); `CHK(resp, dsdt_pkg::RESP_OKAY)
        rdx(8'h34); `CHK(rdat, 32'h00ff_0000)
        // test mode written before the pll key must stay inert
        wr(8'h30, 32'h0001_c10c, 4'hf);
        rdx(8'h40); `CHK(rdat, 32'h0000_0000)
        wr(8'h00, 32'hd000_0000, 4'hf);
        rdx(8'h00); `CHK(rdat, 32'hd000_0000)
        rdx(8'h30); `CHK(rdat, 32'h0001_c10c)
        `CHK(resp, dsdt_pkg::RESP_OKAY)
        corr <= 16'sh6000; lin <= -16'sh6000;
        meas(); `CHK(ones * 8 > tot * 6, 1'b1)
        rdx(8'h40); `CHK(rdat & 32'h0000_0005, 32'h0000_0001)
        corr <= -16'sh6000;
        meas(); `CHK(ones * 8 < tot * 2, 1'b1)
        `CHK(tot > 16'd80, 1'b1)
        wr(8'h30, 32'h0001_c11c, 4'hf); corr <= 16'sh6000;
        meas(); `CHK(ones * 8 < tot * 2, 1'b1)
        wr(8'h30, 32'h0002_811c, 4'hf);
        wr(8'h34, 32'h0fff_0000, 4'hf); lin <= 16'sd8190;
        meas(); `CHK(ones * 20 > tot * 9 && ones * 20 < tot * 11, 1'b1)
        wr(8'h34, 32'h8026_000d, 4'hf); lin <= 16'sd1576;
        meas(); `CHK(ones * 20 > tot * 13, 1'b1)
        wr(8'h30, 32'h0002_813c, 4'hf);
        meas(); `CHK(ren, 1'b0)
        `CHK(tot > 16'd150, 1'b1)
        rdx(8'h40); `CHK(rdat & 32'h0000_0005, 32'h0000_0005)
        @(posedge aclk); ddi <= 1;
        @(negedge aclk); `CHK(ddo, 1'b1)
        @(posedge aclk); ddi <= 0;
        @(negedge aclk); `CHK(ddo, 1'b0)
        // output on but clock-out left off: no stream clock on the pin
        wr(8'h30, 32'h0001_c00c, 4'hf);
        meas(); `CHK(tot, 16'h0000)
        rdx(8'h40); `CHK(rdat[0], 1'b1)
        wr(8'h30, 32'h0000_0000, 4'hf);
        meas(); `CHK(tot, 16'h0000)
        `CHK(tbit, 1'b0)
        tally_and_finish();
    end
endmodule
`default_nettype wire
